// ===== shared/aeof_pkg.sv
// aeof_pkg: constants, types and register map of the event output formatter
// assumes: one 20 MHz system clock, plain register port, external fifo with full flag
package aeof_pkg;
   // ----------------------------------------------------------------
   // register map (word offsets on the plain register port)
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_VERSION = 8'h00;
   localparam logic [7:0] ADDR_TRIGGER_COUNT = 8'h01;
   localparam logic [7:0] ADDR_RESERVED = 8'h02;
   localparam logic [7:0] ADDR_PROCESS_CONTROL = 8'h03;
   localparam logic [7:0] ADDR_ZERO_MASK = 8'h04;
   // ----------------------------------------------------------------
   // field layouts
   // ----------------------------------------------------------------
   localparam int VER_CMD_BIT = 15;
   localparam int CTL_RUN_BIT = 3;
   localparam int CTL_TEST_BIT = 7;
   localparam int CTL_PULSES_LSB = 4;
   localparam logic [15:0] CTL_RESET = 16'h0000;
   localparam logic [15:0] MASK_RESET = 16'h0000;
   // ----------------------------------------------------------------
   // modes
   // ----------------------------------------------------------------
   localparam logic [2:0] MODE_RAW = 3'h0;
   localparam logic [2:0] MODE_PULSE = 3'h1;
   localparam logic [2:0] MODE_INTEGRAL = 3'h2;
   localparam logic [2:0] MODE_TIMING = 3'h3;
   localparam logic [2:0] MODE_COMBINED = 3'h7;
   // ----------------------------------------------------------------
   // word formats and buffer addresses
   // ----------------------------------------------------------------
   localparam logic [35:0] TRAILER_WORD = 36'h2E8000000;
   localparam logic [3:0] HDR_TOP = 4'h1;
   localparam logic [3:0] HDR_TYPE = 4'h2;
   localparam logic [3:0] TS_TYPE = 4'h3;
   localparam logic [3:0] RAW1_TYPE = 4'h4;
   localparam logic [3:0] PTIME_TYPE = 4'h8;
   localparam logic [11:0] ADDR_HOLD_RAW = 12'h005;
   localparam logic [11:0] ADDR_HOLD_PULSE = 12'h006;
   localparam logic [7:0] READY_MIN = 8'h01;

   typedef struct packed {
      logic [11:0] first;
      logic [11:0] last;
   } aeof_span_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } aeof_bus_req_t;

   typedef enum logic [7:0] {
      ST_IDLE = 8'b0000_0001,
      ST_POP = 8'b0000_0010,
      ST_HEAD = 8'b0000_0100,
      ST_TSHI = 8'b0000_1000,
      ST_TSLO = 8'b0001_0000,
      ST_FIRST = 8'b0010_0000,
      ST_DATA = 8'b0100_0000,
      ST_TRAIL = 8'b1000_0000
   } aeof_state_t;
endpackage

// ===== core/aeof_formatter.sv
// aeof_formatter: builds 36-bit event words from the processing buffers into the fifo
// assumes: buffers answer read data combinationally from the address, fifo takes on clock edge
`timescale 1ns/100ps
module aeof_formatter #(
   parameter int NCH = 16,
   parameter int AW = 12,
   parameter logic [14:0] CODE_VERSION = 15'h0001 // arbitrary value
) (
   input wire logic clk,
   input wire logic rst,
   input wire aeof_pkg::aeof_bus_req_t bus_req,
   output logic [15:0] bus_rdata,
   input wire logic converter_ready,
   input wire logic [7:0] ready_window_count [NCH],
   output logic [NCH-1:0] ready_window_done,
   output logic [NCH-1:0] span_pop,
   input wire aeof_pkg::aeof_span_t span_in [NCH],
   output logic [AW-1:0] proc_buffer_addr_out,
   input wire logic [35:0] proc_buffer_read_data [NCH],
   input wire logic [26:0] trigger_number,
   input wire logic [47:0] trigger_time,
   input wire logic [8:0] trigger_window_length,
   output logic [35:0] fifo_data,
   output logic fifo_write,
   output logic fifo_clk_en,
   input wire logic fifo_full,
   output logic [NCH-1:0] channel_zero,
   output logic test_mode,
   output logic [1:0] pulse_count_sel,
   output logic [2:0] mode_sel
);
   localparam int CW = $clog2(NCH);
   // ----------------------------------------------------------------
   // register file
   // ----------------------------------------------------------------
   logic [15:0] process_control;
   logic [15:0] channel_zero_mask;
   logic [15:0] trigger_count;
   logic conv_ready_s1, conv_ready_s2;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         conv_ready_s1 <= 1'b0;
         conv_ready_s2 <= 1'b0;
      end else begin
         conv_ready_s1 <= converter_ready;
         conv_ready_s2 <= conv_ready_s1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         process_control <= aeof_pkg::CTL_RESET;
         channel_zero_mask <= aeof_pkg::MASK_RESET;
      end else if (bus_req.wr) begin
         if (bus_req.addr == aeof_pkg::ADDR_PROCESS_CONTROL)
            process_control <= bus_req.wdata;
         if (bus_req.addr == aeof_pkg::ADDR_ZERO_MASK)
            channel_zero_mask <= bus_req.wdata;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bus_rdata <= 16'h0000;
      end else if (bus_req.rd) begin
         case (bus_req.addr)
            aeof_pkg::ADDR_VERSION: bus_rdata <= {conv_ready_s2, CODE_VERSION};
            aeof_pkg::ADDR_TRIGGER_COUNT: bus_rdata <= trigger_count;
            aeof_pkg::ADDR_PROCESS_CONTROL: bus_rdata <= process_control;
            aeof_pkg::ADDR_ZERO_MASK: bus_rdata <= channel_zero_mask;
            default: bus_rdata <= 16'h0000;
         endcase
      end else begin
         bus_rdata <= 16'h0000;
      end
   end

   assign mode_sel = process_control[2:0];
   assign pulse_count_sel = process_control[aeof_pkg::CTL_PULSES_LSB +: 2];
   assign test_mode = process_control[aeof_pkg::CTL_TEST_BIT];
   assign channel_zero = channel_zero_mask[NCH-1:0];

   // ----------------------------------------------------------------
   // main sequencer
   // ----------------------------------------------------------------
   aeof_pkg::aeof_state_t state;
   logic [CW-1:0] chan;
   logic [AW-1:0] addr_cnt;
   logic [AW-1:0] last_addr;
   logic [2:0] run_mode;
   logic timing_pass;
   logic all_ready;
   logic stall;
   logic [35:0] rd_word;
   logic at_last;

   always_comb begin
      all_ready = 1'b1;
      for (int i = 0; i < NCH; i++) begin
         if (ready_window_count[i] <= aeof_pkg::READY_MIN)
            all_ready = 1'b0;
      end
   end

   assign stall = fifo_full;
   assign rd_word = proc_buffer_read_data[chan];
   assign at_last = (addr_cnt == last_addr);
   assign proc_buffer_addr_out = addr_cnt;

   // hold address per mode while the inserted word is built
   function automatic logic [AW-1:0] hold_addr(input logic [2:0] m, input logic tp);
      if (m == aeof_pkg::MODE_RAW || (m == aeof_pkg::MODE_COMBINED && !tp))
         hold_addr = AW'(aeof_pkg::ADDR_HOLD_RAW);
      else
         hold_addr = AW'(aeof_pkg::ADDR_HOLD_PULSE);
   endfunction

   function automatic logic is_raw(input logic [2:0] m, input logic tp);
      is_raw = (m == aeof_pkg::MODE_RAW) || (m == aeof_pkg::MODE_COMBINED && !tp);
   endfunction

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= aeof_pkg::ST_IDLE;
         chan <= '0;
         addr_cnt <= '0;
         last_addr <= '0;
         run_mode <= aeof_pkg::MODE_RAW;
         timing_pass <= 1'b0;
         trigger_count <= 16'h0000;
      end else if (!stall) begin
         case (state)
            aeof_pkg::ST_IDLE: begin
               chan <= '0;
               timing_pass <= 1'b0;
               if (all_ready && process_control[aeof_pkg::CTL_RUN_BIT]) begin
                  run_mode <= process_control[2:0];
                  state <= aeof_pkg::ST_POP;
               end
            end
            aeof_pkg::ST_POP: begin
               addr_cnt <= AW'(span_in[chan].first);
               last_addr <= AW'(span_in[chan].last);
               state <= (chan == '0 && !timing_pass) ? aeof_pkg::ST_HEAD : aeof_pkg::ST_FIRST;
            end
            aeof_pkg::ST_HEAD: begin
               addr_cnt <= addr_cnt + 1'b1;
               trigger_count <= trigger_count + 16'h0001;
               state <= aeof_pkg::ST_TSHI;
            end
            aeof_pkg::ST_TSHI: begin
               addr_cnt <= addr_cnt + 1'b1;
               state <= aeof_pkg::ST_TSLO;
            end
            aeof_pkg::ST_TSLO: begin
               state <= aeof_pkg::ST_FIRST;
            end
            aeof_pkg::ST_FIRST: begin
               // address jumps to the hold address, or steps on, while the first word is assembled
               if (addr_cnt < hold_addr(run_mode, timing_pass))
                  addr_cnt <= hold_addr(run_mode, timing_pass);
               else
                  addr_cnt <= addr_cnt + 1'b1;
               state <= aeof_pkg::ST_DATA;
            end
            aeof_pkg::ST_DATA: begin
               if (at_last) begin
                  if (chan == CW'(NCH - 1)) begin
                     chan <= '0;
                     if (run_mode == aeof_pkg::MODE_COMBINED && !timing_pass) begin
                        timing_pass <= 1'b1;
                        state <= aeof_pkg::ST_POP;
                     end else begin
                        state <= aeof_pkg::ST_TRAIL;
                     end
                  end else begin
                     chan <= chan + 1'b1;
                     state <= aeof_pkg::ST_POP;
                  end
               end else begin
                  addr_cnt <= addr_cnt + 1'b1;
               end
            end
            aeof_pkg::ST_TRAIL: begin
               state <= aeof_pkg::ST_IDLE;
            end
            default: state <= aeof_pkg::ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // handshakes to processing buffers
   // ----------------------------------------------------------------
   always_comb begin
      span_pop = '0;
      ready_window_done = '0;
      if (!stall && state == aeof_pkg::ST_POP)
         span_pop[chan] = 1'b1;
      if (!stall && state == aeof_pkg::ST_TRAIL)
         ready_window_done = '1;
   end

   // ----------------------------------------------------------------
   // word assembly, one block shared by all modes
   // ----------------------------------------------------------------
   logic [35:0] next_word;
   logic next_write;
   logic [3:0] ch4;
   assign ch4 = 4'(chan);

   always_comb begin
      next_word = 36'h0;
      next_write = 1'b0;
      case (state)
         aeof_pkg::ST_HEAD: begin
            next_word = {aeof_pkg::HDR_TOP, 1'b1, aeof_pkg::HDR_TYPE, trigger_number};
            next_write = 1'b1;
         end
         aeof_pkg::ST_TSHI: begin
            next_word = {4'h0, 1'b1, aeof_pkg::TS_TYPE, 3'h0, trigger_time[47:24]};
            next_write = 1'b1;
         end
         aeof_pkg::ST_TSLO: begin
            next_word = {9'h000, 3'h0, trigger_time[23:0]};
            next_write = 1'b1;
         end
         aeof_pkg::ST_FIRST: begin
            next_write = 1'b1;
            if (is_raw(run_mode, timing_pass))
               next_word = {4'h0, 1'b1, aeof_pkg::RAW1_TYPE, ch4, 14'h0, 9'(trigger_window_length)};
            else if (run_mode == aeof_pkg::MODE_PULSE)
               next_word = {4'h0, 1'b1, aeof_pkg::RAW1_TYPE, ch4, rd_word[22:21],
                            11'h0, rd_word[9:0]};
            else
               next_word = {4'h0, 1'b1, aeof_pkg::PTIME_TYPE, ch4, rd_word[22:21],
                            5'h0, rd_word[15:0]};
         end
         aeof_pkg::ST_DATA: begin
            next_write = 1'b1; // pair count tracks last address
            case (run_mode)
               aeof_pkg::MODE_PULSE:
                  next_word = {7'h0, rd_word[28:16], 3'h0, rd_word[12:0]};
               aeof_pkg::MODE_INTEGRAL: begin
                  // only integral words carry a set type bit; leftovers dropped
                  next_write = rd_word[31];
                  next_word = {4'h0, rd_word[31:27], ch4, rd_word[22:21], 2'h0,
                               rd_word[18:0]};
               end
               default:
                  next_word = {rd_word[35:27], (is_raw(run_mode, timing_pass) ?
                               rd_word[26:23] : ch4), rd_word[22:0]};
            endcase
         end
         aeof_pkg::ST_TRAIL: begin
            next_word = aeof_pkg::TRAILER_WORD;
            next_write = 1'b1;
         end
         default: begin
            next_word = 36'h0;
            next_write = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fifo_data <= 36'h0;
         fifo_write <= 1'b0;
      end else if (!stall) begin
         fifo_data <= next_word;
         fifo_write <= next_write;
      end else begin
         fifo_write <= fifo_write; // held until fifo has room
      end
   end

   // fifo clock runs only while an event is being moved and fifo has room
   assign fifo_clk_en = (state != aeof_pkg::ST_IDLE || fifo_write) && !stall;
endmodule

// ===== dv/aeof_formatter_asserts.sv
// aeof_formatter_asserts: port checks of the event output formatter
// assumes: bound to aeof_formatter, one clock, rst async high
`timescale 1ns/100ps
module aeof_formatter_asserts #(
   parameter int NCH = 16,
   parameter logic [14:0] CODE_VERSION = 15'h0001
) (
   input wire logic clk,
   input wire logic rst,
   input wire aeof_pkg::aeof_bus_req_t bus_req,
   input wire logic [15:0] bus_rdata,
   input wire logic [NCH-1:0] ready_window_done,
   input wire logic [NCH-1:0] span_pop,
   input wire logic [26:0] trigger_number,
   input wire logic [47:0] trigger_time,
   input wire logic [35:0] fifo_data,
   input wire logic fifo_write,
   input wire logic fifo_clk_en,
   input wire logic fifo_full,
   input wire logic test_mode,
   input wire logic [1:0] pulse_count_sel,
   input wire logic [2:0] mode_sel
);
   // ---------------------------------------------
   // word sequences
   // ---------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   sequence s_head;
      fifo_write && fifo_data[35:27] == 9'h032;
   endsequence
   sequence s_tshi;
      fifo_write && fifo_data == {12'h098, trigger_time[47:24]};
   endsequence
   sequence s_tslo;
      fifo_write && fifo_data == {12'h000, trigger_time[23:0]};
   endsequence
   AST_HEAD_FIELDS: assert property (s_head |-> fifo_data[26:0] == trigger_number)
      else $error("header trigger field wrong");
   AST_STAMP_HI: assert property (s_head ##0 !fifo_full |=> s_tshi)
      else $error("upper stamp word not after header");
   AST_STAMP_LO: assert property (s_tshi ##0 !fifo_full |=> s_tslo)
      else $error("lower stamp word not after upper");
   AST_FULL_GATE: assert property (fifo_full |-> !fifo_clk_en)
      else $error("fifo clock runs while full");
   AST_DONE_TRAIL: assert property ((|ready_window_done) && !fifo_full |=>
      fifo_write && fifo_data == aeof_pkg::TRAILER_WORD)
      else $error("trailer missing after window done");
   AST_DONE_ALL: assert property ((|ready_window_done) |-> (&ready_window_done))
      else $error("window done not on every channel");
   AST_POP_ONE: assert property ($onehot0(span_pop))
      else $error("more than one channel popped");
   AST_RDATA_QUIET: assert property (!$past(bus_req.rd) |-> bus_rdata == 16'h0000)
      else $error("read data outside read cycle");
   AST_CTRL_FIELDS: assert property ($past(bus_req.wr) &&
      $past(bus_req.addr) == aeof_pkg::ADDR_PROCESS_CONTROL |-> mode_sel ==
      $past(bus_req.wdata[2:0]) && pulse_count_sel == $past(bus_req.wdata[5:4]) &&
      test_mode == $past(bus_req.wdata[7]))
      else $error("control fields not taken from write");
   AST_VERSION: assert property ($past(bus_req.rd) &&
      $past(bus_req.addr) == aeof_pkg::ADDR_VERSION |-> bus_rdata[14:0] == CODE_VERSION)
      else $error("version code wrong");
endmodule
bind aeof_formatter aeof_formatter_asserts #(.NCH(NCH), .CODE_VERSION(CODE_VERSION)) u_chk (
   .clk, .rst, .bus_req, .bus_rdata, .ready_window_done, .span_pop, .trigger_number,
   .trigger_time, .fifo_data, .fifo_write, .fifo_clk_en, .fifo_full, .test_mode,
   .pulse_count_sel, .mode_sel);

// ===== dv/aeof_fifo_model.sv
// aeof_fifo_model: external event fifo, records every accepted word
// assumes: same clock as the formatter, full level set by the bench
`timescale 1ns/100ps
module aeof_fifo_model (
   input wire logic clk,
   input wire logic [35:0] fifo_data,
   input wire logic fifo_write,
   input wire logic fifo_clk_en,
   input wire logic hold_off,
   output logic fifo_full
);
   logic [35:0] words [$];
   // full is a plain level; a word offered while full is not taken
   assign fifo_full = hold_off;
   always @(posedge clk) begin
      if (fifo_write && fifo_clk_en && !fifo_full) words.push_back(fifo_data);
   end
endmodule

// ===== dv/adc_event_output_formatter_bench.sv
// adc_event_output_formatter_bench: register and event scenarios
// assumes: two channels, buffers answer combinationally from the address
`timescale 1ns/100ps
module adc_event_output_formatter_bench;
   localparam int NCH = 2;
   localparam logic [14:0] CODE = 15'h0155; // arbitrary value
   logic clk = 1'b0;
   logic rst = 1'b1;
   aeof_pkg::aeof_bus_req_t bus_req = '0;
   logic [15:0] rdata;
   logic conv_rdy = 1'b0;
   logic stall = 1'b0;
   logic [7:0] rwc [NCH];
   logic [NCH-1:0] done, pop, zero;
   aeof_pkg::aeof_span_t span [NCH];
   logic [11:0] addr;
   logic [35:0] pdat [NCH];
   logic [26:0] trig_num = 27'h3ABCDEF;
   logic [47:0] trig_time = 48'h123456789ABC;
   logic [35:0] fdata;
   logic fwr, fclk_en, full, tmode;
   logic [1:0] psel;
   logic [2:0] msel;
   int n_mismatch = 0, compares = 0, n_done = 0, n_pop = 0;
   // ---------------------------------------------
   // design, far side and clocking
   // ---------------------------------------------
   always #25 clk = ~clk;
   always_comb for (int i = 0; i < NCH; i++) pdat[i] = {24'hA00000, addr};
   aeof_formatter #(.NCH(NCH), .CODE_VERSION(CODE)) u_aeof_formatter (.clk(clk), .rst(rst),
      .bus_req(bus_req), .bus_rdata(rdata), .converter_ready(conv_rdy),
      .ready_window_count(rwc), .ready_window_done(done), .span_pop(pop), .span_in(span),
      .proc_buffer_addr_out(addr), .proc_buffer_read_data(pdat), .trigger_number(trig_num),
      .trigger_time(trig_time), .trigger_window_length(9'h00C), .fifo_data(fdata),
      .fifo_write(fwr), .fifo_clk_en(fclk_en), .fifo_full(full), .channel_zero(zero),
      .test_mode(tmode), .pulse_count_sel(psel), .mode_sel(msel));
   aeof_fifo_model u_aeof_fifo_model (.clk(clk), .fifo_data(fdata), .fifo_write(fwr),
      .fifo_clk_en(fclk_en), .hold_off(stall), .fifo_full(full));
   // host side: one window taken per done pulse
   always @(posedge clk) begin
      if (|done) n_done <= n_done + 1;
      if (|pop) n_pop <= n_pop + 1;
      for (int i = 0; i < NCH; i++) if (done[i] && rwc[i] > 0) rwc[i] <= rwc[i] - 8'h01;
   end
   task automatic check(string what, logic [35:0] seen, logic [35:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic test_done();
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic wr_reg(logic [7:0] a, logic [15:0] d);
      @(posedge clk);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus_req.wr <= 1'b0;
   endtask
   task automatic chk_reg(logic [7:0] a, logic [15:0] exp);
      @(posedge clk);
      bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus_req.rd <= 1'b0;
      @(negedge clk);
      check($sformatf("reg %h", a), {20'h0, rdata}, {20'h0, exp});
   endtask
   // ---------------------------------------------
   // scenarios
   // ---------------------------------------------
   task automatic t_regs();
      chk_reg(aeof_pkg::ADDR_PROCESS_CONTROL, aeof_pkg::CTL_RESET);
      chk_reg(aeof_pkg::ADDR_ZERO_MASK, aeof_pkg::MASK_RESET);
      wr_reg(aeof_pkg::ADDR_ZERO_MASK, 16'h0002);
      chk_reg(aeof_pkg::ADDR_ZERO_MASK, 16'h0002);
      check("zero mask", {34'h0, zero}, 36'h2);
      wr_reg(aeof_pkg::ADDR_PROCESS_CONTROL, 16'h00B7);
      chk_reg(aeof_pkg::ADDR_PROCESS_CONTROL, 16'h00B7);
      check("fields", {30'h0, tmode, psel, msel}, 36'h3F);
      chk_reg(aeof_pkg::ADDR_RESERVED, 16'h0000);
      chk_reg(8'h3F, 16'h0000);
      wr_reg(aeof_pkg::ADDR_TRIGGER_COUNT, 16'hFFFF);
      chk_reg(aeof_pkg::ADDR_TRIGGER_COUNT, 16'h0000);
      conv_rdy <= 1'b1;
      repeat (4) @(posedge clk);
      chk_reg(aeof_pkg::ADDR_VERSION, {1'b1, CODE});
      conv_rdy <= 1'b0;
      repeat (4) @(posedge clk);
      chk_reg(aeof_pkg::ADDR_VERSION, {1'b0, CODE});
      wr_reg(aeof_pkg::ADDR_ZERO_MASK, 16'h0000);
   endtask
   task automatic t_hold();
      int w0;
      w0 = u_aeof_fifo_model.words.size();
      rwc[0] <= 8'h02;
      wr_reg(aeof_pkg::ADDR_PROCESS_CONTROL, 16'h0008);
      repeat (30) @(posedge clk);
      check("start with one window", u_aeof_fifo_model.words.size(), w0);
      wr_reg(aeof_pkg::ADDR_PROCESS_CONTROL, 16'h0000);
      rwc[1] <= 8'h02;
      repeat (30) @(posedge clk);
      check("start without run", u_aeof_fifo_model.words.size(), w0);
   endtask
   task automatic t_event(logic [2:0] mode, int stall_at);
      int w0, p0, d0;
      logic [8:0] ft;
      w0 = u_aeof_fifo_model.words.size();
      p0 = n_pop;
      d0 = n_done;
      for (int i = 0; i < NCH; i++) rwc[i] <= 8'h02;
      wr_reg(aeof_pkg::ADDR_PROCESS_CONTROL, {12'h000, 1'b1, mode});
      for (int c = 0; c < 2000 && n_done == d0; c++) begin
         @(posedge clk);
         stall <= (c >= stall_at && c < stall_at + 6);
      end
      if (n_done == d0) begin
         check("event end", 0, 1);
         test_done();
      end
      repeat (30) @(posedge clk);
      check("header", u_aeof_fifo_model.words[w0], {9'h032, trig_num});
      check("stamp hi", u_aeof_fifo_model.words[w0+1], {12'h098, trig_time[47:24]});
      check("stamp lo", u_aeof_fifo_model.words[w0+2], {12'h000, trig_time[23:0]});
      ft = (mode == aeof_pkg::MODE_INTEGRAL || mode == aeof_pkg::MODE_TIMING) ? 9'h018 : 9'h014;
      if (mode != aeof_pkg::MODE_PULSE)
         check("first type", u_aeof_fifo_model.words[w0+3][35:23], {ft, 4'h0});
      check("trailer", u_aeof_fifo_model.words[$], aeof_pkg::TRAILER_WORD);
      check("done pulses", n_done - d0, 1);
      check("windows left", rwc[0], 8'h01);
      if (mode == aeof_pkg::MODE_RAW || mode == aeof_pkg::MODE_COMBINED) begin
         check("raw first", u_aeof_fifo_model.words[w0+3],
            {9'h014, 4'h0, 14'h0, 9'h00C});
         check("raw at hold", u_aeof_fifo_model.words[w0+4], {24'hA00000, 12'h005});
         check("raw last", u_aeof_fifo_model.words[w0+10], {24'hA00000, 12'h00B});
         check("next channel", u_aeof_fifo_model.words[w0+11],
            {9'h014, 4'h1, 14'h0, 9'h00C});
      end
      if (mode == aeof_pkg::MODE_PULSE)
         check("pulse pair", u_aeof_fifo_model.words[w0+4], 36'h000000006);
      if (mode == aeof_pkg::MODE_INTEGRAL)
         check("integral words", u_aeof_fifo_model.words.size() - w0, 6);
      if (mode == aeof_pkg::MODE_COMBINED) begin
         check("timing pass", u_aeof_fifo_model.words[w0+19][35:27], 9'h018);
         check("pops", n_pop - p0, 2 * NCH);
      end else begin
         check("pops", n_pop - p0, NCH);
      end
      wr_reg(aeof_pkg::ADDR_PROCESS_CONTROL, 16'h0000);
   endtask
   initial begin
      logic [2:0] modes [5];
      modes = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
      for (int i = 0; i < NCH; i++) begin
         rwc[i] = 8'h01;
         span[i] = '{first: 12'h000, last: 12'h00B};
      end
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_hold();
      for (int k = 0; k < 5; k++) t_event(modes[k], (k == 0) ? 2 : 5000);
      chk_reg(aeof_pkg::ADDR_TRIGGER_COUNT, 16'h0005);
      test_done();
   end
endmodule
